// ==== design/tmr_pkg.sv ====
// Shared constants and types for the 16-bit timer/counter core
package tmr_pkg;
   // Register offsets on the I/O register port
   localparam logic [5:0] OFS_CAP_L = 6'h26;
   localparam logic [5:0] OFS_CAP_H = 6'h27;
   localparam logic [5:0] OFS_CMPB_L = 6'h28;
   localparam logic [5:0] OFS_CMPB_H = 6'h29;
   localparam logic [5:0] OFS_CMPA_L = 6'h2a;
   localparam logic [5:0] OFS_CMPA_H = 6'h2b;
   localparam logic [5:0] OFS_CNT_L = 6'h2c;
   localparam logic [5:0] OFS_CNT_H = 6'h2d;
   localparam logic [5:0] OFS_CTRL_B = 6'h2e;
   localparam logic [5:0] OFS_CTRL_A = 6'h2f;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // Field positions
   localparam int WAVE_LO_POS = 0;
   localparam int WAVE_HI_POS = 3;
   localparam int CLK_SEL_POS = 0;
   localparam int EDGE_SEL_POS = 6;
   localparam int FILTER_EN_POS = 7;
   localparam int FORCE_POS = 2;
   localparam int CTRL_B_GAP_POS = 5;
   // Fixed TOP and BOTTOM values
   localparam logic [15:0] TOP_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] BOTTOM = 16'h0000;
   // Clock source codes
   localparam logic [2:0] CLK_STOP = 3'h0;
   localparam logic [2:0] CLK_DIV1 = 3'h1;
   localparam logic [2:0] CLK_DIV8 = 3'h2;
   localparam logic [2:0] CLK_DIV64 = 3'h3;
   localparam logic [2:0] CLK_DIV256 = 3'h4;
   localparam logic [2:0] CLK_DIV1024 = 3'h5;
   localparam logic [2:0] CLK_EXT_FALL = 3'h6;
   localparam logic [2:0] CLK_EXT_RISE = 3'h7;
   // Prescaler width and noise filter length
   localparam int PRESC_W = 10;
   localparam int FILTER_LEN = 4;
   typedef enum logic [1:0] {
      KIND_NORMAL = 2'b00,
      KIND_FAST = 2'b01,
      KIND_PHASE = 2'b10,
      KIND_PFC = 2'b11
   } tmr_kind_e;
   typedef enum logic {
      DIR_UP = 1'b0,
      DIR_DOWN = 1'b1
   } tmr_dir_e;
endpackage : tmr_pkg

// ==== design/tmr_prescale.sv ====
// Prescaler and clock source selection producing the timer count enable
`timescale 1ns/1ps
module tmr_prescale import tmr_pkg::*; (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Selection and pin
   input wire logic [2:0] clock_source_sel,
   input wire logic external_count_pin,
   // Count enable
   output logic timer_count_enable
);
   typedef struct packed {
      logic [PRESC_W-1:0] div;
      logic ext_prev;
      logic ext_cur;
   } tmr_presc_s;
   tmr_presc_s st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      st_next.div = st_reg.div + {{(PRESC_W-1){1'b0}}, 1'b1};
      st_next.ext_prev = st_reg.ext_cur;
      st_next.ext_cur = external_count_pin; // Pin sampled whatever its direction
   end

   always_comb begin
      unique case (clock_source_sel)
         CLK_STOP: timer_count_enable = 1'b0;
         CLK_DIV1: timer_count_enable = 1'b1;
         CLK_DIV8: timer_count_enable = &st_reg.div[2:0];
         CLK_DIV64: timer_count_enable = &st_reg.div[5:0];
         CLK_DIV256: timer_count_enable = &st_reg.div[7:0];
         CLK_DIV1024: timer_count_enable = &st_reg.div[9:0];
         CLK_EXT_FALL: timer_count_enable = st_reg.ext_prev & ~st_reg.ext_cur;
         CLK_EXT_RISE: timer_count_enable = ~st_reg.ext_prev & st_reg.ext_cur;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   AST_DIV8_RATE: assert property (@(posedge sys_clk) disable iff (!arst_n)
      clock_source_sel == CLK_DIV8 && timer_count_enable ##1 clock_source_sel == CLK_DIV8
      |-> (!timer_count_enable || clock_source_sel != CLK_DIV8) [*7]
      ##1 (timer_count_enable || clock_source_sel != CLK_DIV8))
      else $error("divide by 8 enable spacing wrong");
   AST_EXT_RISE: assert property (@(posedge sys_clk) disable iff (!arst_n)
      clock_source_sel == CLK_EXT_RISE && external_count_pin && !$past(external_count_pin)
      |=> timer_count_enable)
      else $error("rising edge on count pin did not count");
endmodule : tmr_prescale

// ==== design/tmr_capture.sv ====
// Capture input noise filter and edge detector
`timescale 1ns/1ps
module tmr_capture import tmr_pkg::*; (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Pin and controls
   input wire logic capture_input_pin,
   input wire logic capture_noise_filter_en,
   input wire logic capture_edge_sel,
   input wire logic capture_enable,
   // Trigger pulse
   output logic capture_trig
);
   typedef struct packed {
      logic [FILTER_LEN-1:0] samp;
      logic filt;
      logic prev;
      logic trig;
   } tmr_cap_s;
   tmr_cap_s st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      st_next.samp = {st_reg.samp[FILTER_LEN-2:0], capture_input_pin};
      if (!capture_noise_filter_en) begin
         st_next.filt = capture_input_pin;
      end else if (&st_reg.samp || ~|st_reg.samp) begin
         st_next.filt = st_reg.samp[0];
      end
      st_next.prev = st_reg.filt;
      st_next.trig = capture_enable && (capture_edge_sel ? (!st_reg.prev && st_reg.filt)
                                                       : (st_reg.prev && !st_reg.filt));
   end

   assign capture_trig = st_reg.trig;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   AST_FILTER_AGREE: assert property (@(posedge sys_clk) disable iff (!arst_n)
      capture_noise_filter_en && $past(capture_noise_filter_en) && $changed(st_reg.filt)
      |-> $past(st_reg.samp) == {FILTER_LEN{st_reg.filt}})
      else $error("filtered capture changed without four equal samples");
   AST_EDGE_KIND: assert property (@(posedge sys_clk) disable iff (!arst_n)
      $rose(capture_trig) && $stable(capture_edge_sel)
      |-> $past(st_reg.filt) == capture_edge_sel)
      else $error("capture fired on wrong edge");
endmodule : tmr_capture

// ==== design/tmr_core.sv ====
// 16-bit timer/counter core: mode decode, counting, capture and byte access
// What this block does
// - Four-bit waveform mode from two control-A bits and two control-B bits.
// - Normal counts to 0xFFFF; modes 4/12 clear at compare A/capture; immediate update.
// - Phase-correct modes use 8/9/10-bit or capture/compare A TOP; update TOP.
// - Fast PWM uses fixed or capture/compare A TOP; update BOTTOM, overflow TOP.
// - Modes 8/9 take TOP from capture/compare A; update and overflow BOTTOM.
// - Noise filter changes output only after four equal successive pin samples.
// - Edge select zero picks falling, one picks rising capture edge.
// - Capture copies counter into capture register and raises capture flag.
// - Capture input is disabled while the capture register serves as TOP.
// - Clock select: stop, undivided, divide by 8, 64, 256, 1024.
// - Codes 110 and 111 count falling or rising edges of count pin.
// - Count pin edges advance the counter even when the pin is an output.
// - Counter accessed as two bytes through shared temporary high byte.
// - A counter write blocks all compare matches on the next timer clock.
// - Fully synchronous; the selected timer clock acts as a count enable.
`timescale 1ns/1ps
module tmr_core import tmr_pkg::*; (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // I/O register port
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_we,
   input wire logic io_re,
   output logic [7:0] io_rdata,
   // Pins
   input wire logic capture_input_pin,
   input wire logic external_count_pin,
   // Flag set pulses
   output logic overflow_flag,
   output logic capture_flag,
   output logic match_a_flag,
   output logic match_b_flag
);
   typedef struct packed {
      logic [15:0] cnt;
      tmr_dir_e dir;
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
      logic [15:0] cmp_a_buf;
      logic [15:0] cmp_b_buf;
      logic [15:0] cap;
      logic [7:0] temp;
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic block;
      logic [7:0] rdata;
      logic ovf_p;
      logic cap_p;
      logic ma_p;
      logic mb_p;
   } tmr_core_s;
   tmr_core_s st_reg, st_next;

   logic [3:0] wave_mode_sel;
   logic [15:0] top;
   tmr_kind_e kind;
   logic cap_is_top;
   logic timer_count_enable;
   logic capture_trig;
   logic upd;

   // Mode decode
   always_comb begin
      wave_mode_sel = {st_reg.ctrl_b[WAVE_HI_POS +: 2], st_reg.ctrl_a[WAVE_LO_POS +: 2]};
      top = TOP_MAX;
      kind = KIND_NORMAL;
      cap_is_top = 1'b0;
      unique case (wave_mode_sel)
         4'h0, 4'hd: begin
            top = TOP_MAX;
            kind = KIND_NORMAL;
         end
         4'h4: begin
            top = st_reg.cmp_a;
            kind = KIND_NORMAL;
         end
         4'hc: begin
            top = st_reg.cap;
            kind = KIND_NORMAL;
            cap_is_top = 1'b1;
         end
         4'h1, 4'h2, 4'h3: begin
            top = (wave_mode_sel == 4'h1) ? TOP_8BIT :
                  (wave_mode_sel == 4'h2) ? TOP_9BIT : TOP_10BIT;
            kind = KIND_PHASE;
         end
         4'ha: begin
            top = st_reg.cap;
            kind = KIND_PHASE;
            cap_is_top = 1'b1;
         end
         4'hb: begin
            top = st_reg.cmp_a;
            kind = KIND_PHASE;
         end
         4'h5, 4'h6, 4'h7: begin
            top = (wave_mode_sel == 4'h5) ? TOP_8BIT :
                  (wave_mode_sel == 4'h6) ? TOP_9BIT : TOP_10BIT;
            kind = KIND_FAST;
         end
         4'he: begin
            top = st_reg.cap;
            kind = KIND_FAST;
            cap_is_top = 1'b1;
         end
         4'hf: begin
            top = st_reg.cmp_a;
            kind = KIND_FAST;
         end
         4'h8: begin
            top = st_reg.cap;
            kind = KIND_PFC;
            cap_is_top = 1'b1;
         end
         4'h9: begin
            top = st_reg.cmp_a;
            kind = KIND_PFC;
         end
      endcase
   end

   tmr_prescale u_prescale (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clock_source_sel(st_reg.ctrl_b[CLK_SEL_POS +: 3]),
      .external_count_pin(external_count_pin),
      .timer_count_enable(timer_count_enable)
   );

   tmr_capture u_capture (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .capture_input_pin(capture_input_pin),
      .capture_noise_filter_en(st_reg.ctrl_b[FILTER_EN_POS]),
      .capture_edge_sel(st_reg.ctrl_b[EDGE_SEL_POS]),
      .capture_enable(!cap_is_top),
      .capture_trig(capture_trig)
   );

   // Counting, capture and register access
   always_comb begin
      st_next = st_reg;
      st_next.ovf_p = 1'b0;
      st_next.cap_p = 1'b0;
      st_next.ma_p = 1'b0;
      st_next.mb_p = 1'b0;
      upd = 1'b0;
      if (timer_count_enable) begin
         st_next.block = 1'b0;
         if (!st_reg.block) begin
            st_next.ma_p = (st_reg.cnt == st_reg.cmp_a);
            st_next.mb_p = (st_reg.cnt == st_reg.cmp_b);
         end
         unique case (kind)
            KIND_NORMAL: begin
               st_next.ovf_p = (st_reg.cnt == TOP_MAX);
               if (wave_mode_sel != 4'h0 && wave_mode_sel != 4'hd && st_reg.cnt == top) begin
                  st_next.cnt = BOTTOM;
               end else begin
                  st_next.cnt = st_reg.cnt + 16'h0001;
               end
            end
            KIND_FAST: begin
               if (st_reg.cnt >= top) begin
                  st_next.cnt = BOTTOM;
                  st_next.ovf_p = 1'b1;
                  upd = 1'b1;
               end else begin
                  st_next.cnt = st_reg.cnt + 16'h0001;
               end
            end
            KIND_PHASE, KIND_PFC: begin
               if (st_reg.dir == DIR_UP) begin
                  if (st_reg.cnt >= top) begin
                     st_next.dir = DIR_DOWN;
                     st_next.cnt = (st_reg.cnt == BOTTOM) ? BOTTOM : st_reg.cnt - 16'h0001;
                     upd = (kind == KIND_PHASE);
                  end else begin
                     st_next.cnt = st_reg.cnt + 16'h0001;
                  end
               end else if (st_reg.cnt == BOTTOM) begin
                  st_next.dir = DIR_UP;
                  st_next.cnt = 16'h0001;
               end else begin
                  st_next.cnt = st_reg.cnt - 16'h0001;
                  if (st_reg.cnt == 16'h0001) begin
                     st_next.ovf_p = 1'b1;
                     upd = (kind == KIND_PFC);
                  end
               end
            end
         endcase
      end
      if (kind == KIND_NORMAL || upd) begin
         st_next.cmp_a = st_reg.cmp_a_buf;
         st_next.cmp_b = st_reg.cmp_b_buf;
      end
      if (capture_trig) begin
         st_next.cap = st_reg.cnt;
         st_next.cap_p = 1'b1;
      end
      if (io_we) begin
         unique case (io_addr)
            OFS_CNT_H, OFS_CMPA_H, OFS_CMPB_H, OFS_CAP_H: st_next.temp = io_wdata;
            OFS_CNT_L: begin
               st_next.cnt = {st_reg.temp, io_wdata};
               st_next.block = 1'b1;
            end
            OFS_CMPA_L: st_next.cmp_a_buf = {st_reg.temp, io_wdata};
            OFS_CMPB_L: st_next.cmp_b_buf = {st_reg.temp, io_wdata};
            OFS_CAP_L: st_next.cap = {st_reg.temp, io_wdata};
            OFS_CTRL_A: st_next.ctrl_a = io_wdata & ~(8'h03 << FORCE_POS);
            OFS_CTRL_B: st_next.ctrl_b = io_wdata & ~(8'h01 << CTRL_B_GAP_POS);
            default: st_next.temp = st_reg.temp;
         endcase
      end
      if (io_re) begin
         unique case (io_addr)
            OFS_CNT_L: begin
               st_next.rdata = st_reg.cnt[7:0];
               st_next.temp = st_reg.cnt[15:8];
            end
            OFS_CMPA_L: begin
               st_next.rdata = st_reg.cmp_a_buf[7:0];
               st_next.temp = st_reg.cmp_a_buf[15:8];
            end
            OFS_CMPB_L: begin
               st_next.rdata = st_reg.cmp_b_buf[7:0];
               st_next.temp = st_reg.cmp_b_buf[15:8];
            end
            OFS_CAP_L: begin
               st_next.rdata = st_reg.cap[7:0];
               st_next.temp = st_reg.cap[15:8];
            end
            OFS_CNT_H, OFS_CMPA_H, OFS_CMPB_H, OFS_CAP_H: st_next.rdata = st_reg.temp;
            OFS_CTRL_A: st_next.rdata = st_reg.ctrl_a;
            OFS_CTRL_B: st_next.rdata = st_reg.ctrl_b;
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   assign io_rdata = st_reg.rdata;
   assign overflow_flag = st_reg.ovf_p;
   assign capture_flag = st_reg.cap_p;
   assign match_a_flag = st_reg.ma_p;
   assign match_b_flag = st_reg.mb_p;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   AST_MODE_DECODE: assert property (@(posedge sys_clk) disable iff (!arst_n)
      st_reg.ctrl_b[4:3] == 2'b00 && st_reg.ctrl_a[1:0] == 2'b11 |-> top == TOP_10BIT)
      else $error("mode 3 did not select 10-bit top");
   AST_NORMAL_WRAP: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wave_mode_sel == 4'h0 && timer_count_enable && st_reg.cnt == TOP_MAX && !io_we
      |=> overflow_flag && st_reg.cnt == BOTTOM)
      else $error("normal mode overflow at max missing");
   AST_PHASE_TURN: assert property (@(posedge sys_clk) disable iff (!arst_n)
      wave_mode_sel == 4'h1 && timer_count_enable && st_reg.cnt == TOP_8BIT && !io_we
      |=> st_reg.dir == DIR_DOWN && st_reg.cnt == 16'h00fe && !overflow_flag)
      else $error("phase correct mode did not turn at top");
   AST_FAST_TOP: assert property (@(posedge sys_clk) disable iff (!arst_n)
      kind == KIND_FAST && timer_count_enable && st_reg.cnt == top && !io_we
      |=> overflow_flag && st_reg.cnt == BOTTOM && st_reg.cmp_a == $past(st_reg.cmp_a_buf))
      else $error("fast pwm top handling wrong");
   AST_PFC_BOTTOM: assert property (@(posedge sys_clk) disable iff (!arst_n)
      kind == KIND_PFC && timer_count_enable && st_reg.dir == DIR_DOWN
      && st_reg.cnt == 16'h0001 && !io_we
      |=> overflow_flag ##1 (st_reg.cnt == BOTTOM || st_reg.cnt == 16'h0001))
      else $error("pfc overflow at bottom missing");
   AST_CAPTURE_COPY: assert property (@(posedge sys_clk) disable iff (!arst_n)
      capture_trig && !(io_we && io_addr == OFS_CAP_L)
      |=> capture_flag && st_reg.cap == $past(st_reg.cnt))
      else $error("capture did not copy counter");
   AST_CAPTURE_OFF: assert property (@(posedge sys_clk) disable iff (!arst_n)
      cap_is_top && $past(cap_is_top) |=> !capture_trig)
      else $error("capture fired while capture register is top");
   AST_WRITE_BLOCK: assert property (@(posedge sys_clk) disable iff (!arst_n)
      io_we && io_addr == OFS_CNT_L ##1 timer_count_enable |=> !match_a_flag && !match_b_flag)
      else $error("compare match not blocked after counter write");
   AST_TEMP_PAIR: assert property (@(posedge sys_clk) disable iff (!arst_n)
      io_re && io_addr == OFS_CNT_L ##1 io_re && io_addr == OFS_CNT_H && !$past(io_we)
      |=> io_rdata == $past(st_reg.cnt[15:8], 2))
      else $error("high byte read not from temporary");
endmodule : tmr_core

// ==== bench/tmr_pin_model.sv ====
// Pin-side model driving the capture pin and the external count pin
`timescale 1ns/1ps
module tmr_pin_model (
   // Clock
   input wire logic sys_clk,
   // Pins
   output logic capture_input_pin,
   output logic external_count_pin
);
   initial begin
      capture_input_pin = 1'b0;
      external_count_pin = 1'b0;
   end
   // Capture pin level change just after a clock edge
   task automatic set_cap(input logic v);
      @(posedge sys_clk);
      capture_input_pin <= v;
   endtask : set_cap
   // Count pin pulses, three cycles high and four low
   task automatic ext_edges(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         external_count_pin <= 1'b1;
         repeat (3) @(posedge sys_clk);
         external_count_pin <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask : ext_edges
endmodule : tmr_pin_model

// ==== bench/testbench.sv ====
// Self-checking testbench for the timer core
`timescale 1ns/1ps
module testbench;
   import tmr_pkg::*;
   logic sys_clk, arst_n, io_we, io_re;
   logic [5:0] io_addr;
   logic [7:0] io_wdata, io_rdata;
   logic capture_input_pin, external_count_pin;
   logic overflow_flag, capture_flag, match_a_flag, match_b_flag;
   int n_fail, checked;
   tmr_core u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
      .capture_input_pin(capture_input_pin), .external_count_pin(external_count_pin),
      .overflow_flag(overflow_flag), .capture_flag(capture_flag),
      .match_a_flag(match_a_flag), .match_b_flag(match_b_flag));
   tmr_pin_model u_pins (.sys_clk(sys_clk), .capture_input_pin(capture_input_pin),
      .external_count_pin(external_count_pin));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic test_done;
      $display("checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic check(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi,
      input string what);
      checked++;
      if (!(got >= lo && got <= hi) || $isunknown(got)) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h..%h", $time, what, got, lo, hi);
      end
   endtask : check
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      io_we <= 1'b1;
      io_addr <= a;
      io_wdata <= d;
      @(posedge sys_clk);
      io_we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      io_re <= 1'b1;
      io_addr <= a;
      @(posedge sys_clk);
      io_re <= 1'b0;
      @(negedge sys_clk);
      d = io_rdata;
   endtask : rd
   // High byte first on write, low byte first on read
   task automatic wr16(input logic [5:0] a, input logic [15:0] v);
      wr(a + 6'h01, v[15:8]);
      wr(a, v[7:0]);
   endtask : wr16
   task automatic rd16(input logic [5:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      io_re <= 1'b1;
      io_addr <= a;
      @(posedge sys_clk);
      io_addr <= a + 6'h01;
      @(negedge sys_clk);
      v[7:0] = io_rdata;
      @(posedge sys_clk);
      io_re <= 1'b0;
      @(negedge sys_clk);
      v[15:8] = io_rdata;
   endtask : rd16
   function automatic logic flag_of(input int sel);
      return (sel == 0) ? overflow_flag : (sel == 1) ? match_a_flag :
         (sel == 2) ? match_b_flag : capture_flag;
   endfunction : flag_of
   // Cycles until the selected pulse, bounded
   task automatic wait_pulse(input int sel, input int bound, output int n);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
         if (n > bound) begin
            n_fail++;
            $display("unexpected at %0t: no pulse on flag %0d", $time, sel);
            test_done();
         end
      end while (flag_of(sel) !== 1'b1);
   endtask : wait_pulse
   // Number of pulses seen over a fixed span
   task automatic quiet(input int sel, input int span, output int k);
      k = 0;
      repeat (span) begin
         @(negedge sys_clk);
         if (flag_of(sel) === 1'b1) k++;
      end
   endtask : quiet
   task automatic t_regs;
      logic [7:0] d;
      logic [15:0] v;
      rd(OFS_CTRL_B, d);
      check(d, CTRL_RESET, CTRL_RESET, "control b reset");
      rd(OFS_CNT_L, d);
      check(d, 8'h00, 8'h00, "counter low reset");
      rd(6'h30, d);
      check(d, 8'h00, 8'h00, "unmapped read");
      wr(OFS_CTRL_B, 8'hf8);
      rd(OFS_CTRL_B, d);
      check(d, 8'hd8, 8'hd8, "control b gap bit");
      wr(OFS_CTRL_B, 8'h00);
      wr16(OFS_CNT_L, 16'h1234);
      rd16(OFS_CNT_L, v);
      check(v, 16'h1234, 16'h1234, "counter word");
      $display("test regs done");
   endtask : t_regs
   task automatic t_clock;
      int dv[6] = '{0, 1, 8, 64, 256, 1024};
      int len;
      int e;
      logic [15:0] v;
      for (int c = 0; c < 6; c++) begin
         len = (dv[c] < 2) ? 64 : dv[c] * 4;
         e = (dv[c] == 0) ? 0 : len / dv[c];
         wr16(OFS_CNT_L, 16'h0000);
         wr(OFS_CTRL_B, {5'h00, 3'(c)});
         repeat (len - 2) @(posedge sys_clk);
         wr(OFS_CTRL_B, 8'h00);
         rd16(OFS_CNT_L, v);
         check(v, 16'(e > 0 ? e - 1 : 0), 16'(e + 1), "prescaled count");
      end
      wr16(OFS_CNT_L, 16'hfffe);
      wr(OFS_CTRL_B, {5'h00, CLK_DIV1});
      wait_pulse(0, 8, e);
      check(16'(e), 16'h0001, 16'h0004, "overflow at max");
      wr(OFS_CTRL_B, 8'h00);
      $display("test clock done");
   endtask : t_clock
   // Pulse period per mode; compare a 0x63, compare b 0x10, capture 0x31
   task automatic t_modes;
      int md[14] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15};
      int sl[14] = '{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 2, 0, 0};
      int pr[14] = '{510, 1022, 2046, 100, 256, 512, 1024, 98, 198, 98, 198, 50, 50, 100};
      logic [3:0] m;
      int n;
      for (int i = 0; i < 14; i++) begin
         m = 4'(md[i]);
         wr(OFS_CTRL_B, 8'h00);
         wr(OFS_CTRL_A, 8'h00);
         wr16(OFS_CMPA_L, 16'h0063);
         wr16(OFS_CMPB_L, 16'h0010);
         wr16(OFS_CAP_L, 16'h0031);
         wr16(OFS_CNT_L, 16'h0000);
         wr(OFS_CTRL_A, {6'h00, m[1:0]});
         wr(OFS_CTRL_B, {3'h0, m[3:2], CLK_DIV1});
         repeat (3) wait_pulse(sl[i], 2200, n);
         check(16'(n), 16'(pr[i]), 16'(pr[i]), "mode period");
      end
      wr(OFS_CTRL_B, 8'h00);
      $display("test modes done");
   endtask : t_modes
   // Counter rewritten while running on purpose, to see the match dropped
   task automatic t_block;
      int k;
      wr(OFS_CTRL_A, 8'h00);
      wr16(OFS_CMPA_L, 16'h0063);
      wr16(OFS_CNT_L, 16'h0000);
      wr(OFS_CTRL_B, {5'h01, CLK_DIV1});
      wr16(OFS_CNT_L, 16'h0063);
      quiet(1, 3, k);
      check(16'(k), 16'h0000, 16'h0000, "match after counter write");
      wr(OFS_CTRL_B, 8'h00);
      $display("test block done");
   endtask : t_block
   task automatic t_capture;
      int n1, n2, k;
      logic [15:0] v;
      wr(OFS_CTRL_A, 8'h00);
      wr16(OFS_CNT_L, 16'h1234);
      wr(OFS_CTRL_B, 8'h40);
      u_pins.set_cap(1'b1);
      wait_pulse(3, 10, n1);
      check(16'(n1), 16'h0003, 16'h0004, "capture latency");
      rd16(OFS_CAP_L, v);
      check(v, 16'h1234, 16'h1234, "captured value");
      u_pins.set_cap(1'b0);
      quiet(3, 10, k);
      check(16'(k), 16'h0000, 16'h0000, "falling edge ignored");
      wr(OFS_CTRL_B, 8'h00);
      u_pins.set_cap(1'b1);
      quiet(3, 10, k);
      u_pins.set_cap(1'b0);
      wait_pulse(3, 10, n2);
      check(16'(k), 16'h0000, 16'h0000, "rising edge ignored");
      wr(OFS_CTRL_B, 8'hc0);
      u_pins.set_cap(1'b1);
      repeat (2) @(posedge sys_clk);
      u_pins.set_cap(1'b0);
      quiet(3, 12, k);
      check(16'(k), 16'h0000, 16'h0000, "short glitch filtered");
      u_pins.set_cap(1'b1);
      wait_pulse(3, 16, n2);
      check(16'(n2 - n1), 16'h0004, 16'h0004, "filter delay");
      wr(OFS_CTRL_B, 8'h50);
      u_pins.set_cap(1'b0);
      repeat (4) @(posedge sys_clk);
      u_pins.set_cap(1'b1);
      quiet(3, 12, k);
      check(16'(k), 16'h0000, 16'h0000, "capture off as top");
      wr(OFS_CTRL_B, 8'h00);
      $display("test capture done");
   endtask : t_capture
   task automatic t_ext;
      logic [15:0] v;
      wr16(OFS_CNT_L, 16'h0000);
      wr(OFS_CTRL_B, {5'h00, CLK_EXT_RISE});
      u_pins.ext_edges(5);
      wr(OFS_CTRL_B, 8'h00);
      rd16(OFS_CNT_L, v);
      check(v, 16'h0005, 16'h0005, "rising pin count");
      wr16(OFS_CNT_L, 16'h0000);
      wr(OFS_CTRL_B, {5'h00, CLK_EXT_FALL});
      u_pins.ext_edges(3);
      wr(OFS_CTRL_B, 8'h00);
      rd16(OFS_CNT_L, v);
      check(v, 16'h0003, 16'h0003, "falling pin count");
      $display("test ext done");
   endtask : t_ext
   // Mode 13 is never selected here
   initial begin
      n_fail = 0;
      checked = 0;
      arst_n = 1'b0;
      io_we = 1'b0;
      io_re = 1'b0;
      io_addr = 6'h00;
      io_wdata = 8'h00;
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_regs();
      t_clock();
      t_modes();
      t_block();
      t_capture();
      t_ext();
      test_done();
   end
endmodule : testbench
